// ---- core/cds_alu.sv ----
// Subtract, exclusive-OR, rotate and set-carry arithmetic
`timescale 1ns/1ps
`include "cds_defs.svh"
module cds_alu (
   // Operation
   input  wire cds_pkg::cds_alu_t sel_in,
   input  wire logic              borrow_in,
   // Operands
   input  wire logic [7:0]        a_in,
   input  wire logic [7:0]        b_in,
   input  wire logic [7:0]        flags_in,
   // Result
   output logic [7:0]             res_out,
   output logic [7:0]             flags_out
);

   logic       cin_n;
   logic [8:0] full;
   logic [4:0] low;

   always_comb
   begin
      cin_n     = ~(borrow_in & flags_in[`CDS_F_CARRY]);
      full      = {1'b0, a_in} + {1'b0, ~b_in} + {8'h00, cin_n};
      low       = {1'b0, a_in[3:0]} + {1'b0, ~b_in[3:0]}
                + {4'h0, cin_n};
      res_out   = a_in;
      flags_out = flags_in;
      case (sel_in)
         cds_pkg::alu_sub:
         begin
            res_out                   = full[7:0];
            flags_out[`CDS_F_CARRY]   = ~full[8];
            flags_out[`CDS_F_HALF]    = low[4];
         end
         cds_pkg::alu_xor:
         begin
            res_out                   = a_in ^ b_in;
            flags_out[`CDS_F_CARRY]   = 1'b0;
            flags_out[`CDS_F_HALF]    = 1'b0;
         end
         cds_pkg::alu_rot:
         begin
            res_out                   = {a_in[0], a_in[7:1]};
            flags_out[`CDS_F_CARRY]   = a_in[0];
         end
         default:
            flags_out[`CDS_F_CARRY]   = 1'b1;
      endcase
      if (sel_in == cds_pkg::alu_sub || sel_in == cds_pkg::alu_xor)
      begin
         flags_out[`CDS_F_SIGN]   = res_out[7];
         flags_out[`CDS_F_ZERO]   = (res_out == 8'h00);
         flags_out[`CDS_F_PARITY] = ~^res_out;
      end
   end

endmodule // cds_alu

// ---- core/cds_decode_core.sv ----
// Decoder and sequencer for the subtract, exclusive-OR and exchange subset
`timescale 1ns/1ps
`include "cds_defs.svh"
module cds_decode_core (
   // Clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 srst_in,
   // Program and data memory
   input  wire logic [7:0]           mem_rdata_in,
   output cds_pkg::cds_mem_req_t     mem_req_out,
   // Architectural state
   output logic                      done_out,
   output logic [7:0]                acc_out,
   output logic [7:0]                flags_out,
   output logic [15:0]               pc_out,
   output logic [15:0]               sp_out
);

   cds_pkg::cds_core_st_t st;
   cds_pkg::cds_core_st_t nx;
   cds_pkg::cds_kind_t    kind;
   cds_pkg::cds_alu_t     alu_sel;
   logic [4:0]            last;
   logic [7:0]            alu_b;
   logic [7:0]            alu_res;
   logic [7:0]            alu_flags;
   logic [15:0]           hl;

   function automatic cds_pkg::cds_kind_t op_kind(input logic [7:0] op);
      logic [4:0] grp;
      grp = op[7:3];
      if (op == `CDS_OP_RET_PEVEN || op == `CDS_OP_RET_PODD
          || op == `CDS_OP_RET_ZERO)
         return cds_pkg::k_ret_cond;
      else if (op == `CDS_OP_ROT_RIGHT)
         return cds_pkg::k_rot;
      else if (op == `CDS_OP_SET_CARRY)
         return cds_pkg::k_setc;
      else if (op == `CDS_OP_SUBB_MEM || op == `CDS_OP_SUB_MEM)
         return cds_pkg::k_sub_mem;
      else if (op == `CDS_OP_SUBB_IMM || op == `CDS_OP_SUB_IMM)
         return cds_pkg::k_sub_imm;
      else if (op == `CDS_OP_XOR_MEM)
         return cds_pkg::k_xor_mem;
      else if (op == `CDS_OP_XOR_IMM)
         return cds_pkg::k_xor_imm;
      else if (op == `CDS_OP_PAIR_SP)
         return cds_pkg::k_pair_sp;
      else if (op == `CDS_OP_SWAP_DE)
         return cds_pkg::k_swap_de;
      else if (op == `CDS_OP_SWAP_STK)
         return cds_pkg::k_swap_stk;
      else if (grp == `CDS_GRP_SUBB_REG || grp == `CDS_GRP_SUB_REG)
         return cds_pkg::k_sub_reg;
      else if (grp == `CDS_GRP_XOR_REG)
         return cds_pkg::k_xor_reg;
      else if (op[7:6] == `CDS_RST_TOP && op[2:0] == `CDS_RST_LOW)
         return cds_pkg::k_restart;
      else
         return cds_pkg::k_none;
   endfunction

   function automatic logic [4:0] op_cycles(
      input cds_pkg::cds_kind_t k,
      input logic               take
   );
      case (k)
         cds_pkg::k_ret_cond:
            return take ? `CDS_CYC_RET_YES : `CDS_CYC_RET_NO;
         cds_pkg::k_sub_mem, cds_pkg::k_sub_imm,
         cds_pkg::k_xor_mem, cds_pkg::k_xor_imm:
            return `CDS_CYC_MEM;
         cds_pkg::k_pair_sp:
            return `CDS_CYC_PAIR_SP;
         cds_pkg::k_swap_stk:
            return `CDS_CYC_SWAP_STK;
         cds_pkg::k_restart:
            return `CDS_CYC_RESTART;
         default:
            return `CDS_CYC_REG;
      endcase
   endfunction

   // Condition sampled from flags when the opcode arrives
   function automatic logic cond_take(
      input logic [7:0] op,
      input logic [7:0] flags
   );
      case (op)
         `CDS_OP_RET_PEVEN: return flags[`CDS_F_PARITY];
         `CDS_OP_RET_PODD:  return ~flags[`CDS_F_PARITY];
         `CDS_OP_RET_ZERO:  return flags[`CDS_F_ZERO];
         default:           return 1'b0;
      endcase
   endfunction

   assign kind = op_kind(st.op);
   assign last = op_cycles(kind, st.take) - 5'h01;
   assign hl   = {st.regs[`CDS_IDX_H], st.regs[`CDS_IDX_L]};

   always_comb
   begin
      case (kind)
         cds_pkg::k_xor_reg, cds_pkg::k_xor_mem, cds_pkg::k_xor_imm:
            alu_sel = cds_pkg::alu_xor;
         cds_pkg::k_rot:
            alu_sel = cds_pkg::alu_rot;
         cds_pkg::k_setc:
            alu_sel = cds_pkg::alu_setc;
         default:
            alu_sel = cds_pkg::alu_sub;
      endcase
      if (kind == cds_pkg::k_sub_reg || kind == cds_pkg::k_xor_reg)
         alu_b = st.regs[st.op[2:0]];
      else
         alu_b = st.tmp;
   end

   cds_alu u_alu (
      .sel_in    (alu_sel),
      .borrow_in (st.op[3]),
      .a_in      (st.regs[`CDS_IDX_A]),
      .b_in      (alu_b),
      .flags_in  (st.flags),
      .res_out   (alu_res),
      .flags_out (alu_flags)
   );

   always_comb
   begin
      nx        = st;
      nx.mem.rd = 1'b0;
      nx.mem.wr = 1'b0;
      nx.done   = 1'b0;
      nx.cnt    = st.cnt + 5'h01;
      case (st.fsm)
         cds_pkg::st_fetch:
         begin
            nx.mem.addr = st.pc;
            nx.mem.rd   = 1'b1;
            nx.fsm      = cds_pkg::st_decode;
         end
         cds_pkg::st_decode:
         begin
            nx.op   = mem_rdata_in;
            nx.pc   = st.pc + 16'h0001;
            nx.take = cond_take(mem_rdata_in, st.flags);
            nx.fsm  = cds_pkg::st_exec;
         end
         cds_pkg::st_exec:
         begin
            if (st.cnt == 5'h02)
            begin
               case (kind)
                  cds_pkg::k_sub_imm, cds_pkg::k_xor_imm:
                  begin
                     nx.mem.addr = st.pc;
                     nx.mem.rd   = 1'b1;
                     nx.pc       = st.pc + 16'h0001;
                  end
                  cds_pkg::k_sub_mem, cds_pkg::k_xor_mem:
                  begin
                     nx.mem.addr = hl;
                     nx.mem.rd   = 1'b1;
                  end
                  cds_pkg::k_ret_cond, cds_pkg::k_swap_stk:
                  begin
                     nx.mem.addr = st.sp;
                     nx.mem.rd   = st.take
                                 || kind == cds_pkg::k_swap_stk;
                  end
                  cds_pkg::k_restart:
                  begin
                     nx.mem.addr  = st.sp - 16'h0001;
                     nx.mem.wr    = 1'b1;
                     nx.mem.wdata = st.pc[15:8];
                  end
                  default:
                     nx.mem.addr = st.mem.addr;
               endcase
            end
            if (st.cnt == 5'h03)
            begin
               nx.tmp = mem_rdata_in;
               if ((kind == cds_pkg::k_ret_cond && st.take)
                   || kind == cds_pkg::k_swap_stk)
               begin
                  nx.mem.addr = st.sp + 16'h0001;
                  nx.mem.rd   = 1'b1;
               end
               if (kind == cds_pkg::k_restart)
               begin
                  nx.mem.addr  = st.sp - 16'h0002;
                  nx.mem.wr    = 1'b1;
                  nx.mem.wdata = st.pc[7:0];
                  nx.sp        = st.sp - 16'h0002;
                  nx.pc        = {10'h000, st.op[5:3], 3'h0};
               end
            end
            if (st.cnt == 5'h04)
            begin
               if (kind == cds_pkg::k_ret_cond && st.take)
               begin
                  nx.pc = {mem_rdata_in, st.tmp};
                  nx.sp = st.sp + 16'h0002;
               end
               if (kind == cds_pkg::k_swap_stk)
               begin
                  nx.mem.addr  = st.sp;
                  nx.mem.wr    = 1'b1;
                  nx.mem.wdata = st.regs[`CDS_IDX_L];
                  nx.regs[`CDS_IDX_L] = st.tmp;
                  nx.tmp       = mem_rdata_in;
               end
            end
            if (st.cnt == 5'h05 && kind == cds_pkg::k_swap_stk)
            begin
               nx.mem.addr  = st.sp + 16'h0001;
               nx.mem.wr    = 1'b1;
               nx.mem.wdata = st.regs[`CDS_IDX_H];
               nx.regs[`CDS_IDX_H] = st.tmp;
            end
            if (st.cnt == last)
            begin
               nx.done = 1'b1;
               nx.cnt  = 5'h00;
               nx.fsm  = cds_pkg::st_fetch;
               case (kind)
                  cds_pkg::k_sub_reg, cds_pkg::k_sub_mem,
                  cds_pkg::k_sub_imm, cds_pkg::k_xor_reg,
                  cds_pkg::k_xor_mem, cds_pkg::k_xor_imm,
                  cds_pkg::k_rot, cds_pkg::k_setc:
                  begin
                     nx.regs[`CDS_IDX_A] = alu_res;
                     nx.flags            = alu_flags;
                  end
                  cds_pkg::k_pair_sp:
                     nx.sp = hl;
                  cds_pkg::k_swap_de:
                  begin
                     nx.regs[`CDS_IDX_D] = st.regs[`CDS_IDX_H];
                     nx.regs[`CDS_IDX_E] = st.regs[`CDS_IDX_L];
                     nx.regs[`CDS_IDX_H] = st.regs[`CDS_IDX_D];
                     nx.regs[`CDS_IDX_L] = st.regs[`CDS_IDX_E];
                  end
                  default:
                     nx.tmp = st.tmp;
               endcase
            end
         end
         default:
         begin
            nx.fsm = cds_pkg::st_fetch;
            nx.cnt = 5'h00;
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         st       <= '0;
         st.flags <= `CDS_FLAGS_RST;
         st.pc    <= `CDS_PC_RST;
         st.sp    <= `CDS_SP_RST;
      end
      else
         st <= nx;
   end

   assign mem_req_out = st.mem;
   assign done_out    = st.done;
   assign acc_out     = st.regs[`CDS_IDX_A];
   assign flags_out   = st.flags;
   assign pc_out      = st.pc;
   assign sp_out      = st.sp;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   property p_ret_even;
      st.done && st.op == `CDS_OP_RET_PEVEN
         |-> $past(st.cnt) == (st.take ? 5'h0a : 5'h04);
   endproperty
   a_ret_even: assert property (p_ret_even)
      else $error("parity-even return has wrong length");

   property p_ret_odd;
      st.done && st.op == `CDS_OP_RET_PODD && st.take
         |-> st.pc == {$past(mem_rdata_in, 7), $past(st.tmp, 7)};
   endproperty
   a_ret_odd: assert property (p_ret_odd)
      else $error("parity-odd return did not load popped address");

   property p_take_flag;
      st.fsm == cds_pkg::st_exec && st.op == `CDS_OP_RET_PEVEN
         |-> st.take == st.flags[`CDS_F_PARITY];
   endproperty
   a_take_flag: assert property (p_take_flag)
      else $error("return condition does not follow parity");

   property p_sub_flags;
      st.done && kind == cds_pkg::k_sub_reg
         |-> st.flags[`CDS_F_ZERO] == (acc_out == 8'h00)
             && st.flags[`CDS_F_SIGN] == acc_out[7]
             && st.flags[`CDS_F_PARITY] == ~^acc_out;
   endproperty
   a_sub_flags: assert property (p_sub_flags)
      else $error("subtract flags do not match result");

   property p_carry_only;
      st.done && (kind == cds_pkg::k_rot || kind == cds_pkg::k_setc)
         |-> st.flags[7:1] == $past(st.flags[7:1])
             && $past(st.cnt) == 5'h03;
   endproperty
   a_carry_only: assert property (p_carry_only)
      else $error("rotate or set carry touched other flags");

   property p_mem_len;
      st.done && (kind == cds_pkg::k_sub_mem || kind == cds_pkg::k_xor_mem)
         |-> $past(st.cnt) == 5'h06;
   endproperty
   a_mem_len: assert property (p_mem_len)
      else $error("memory operand instruction not 7 cycles");

   property p_reg_len;
      st.done && (kind == cds_pkg::k_sub_reg || kind == cds_pkg::k_xor_reg)
         |-> $past(st.cnt) == 5'h03;
   endproperty
   a_reg_len: assert property (p_reg_len)
      else $error("register operand instruction not 4 cycles");

   property p_imm_pc;
      st.done
         && (kind == cds_pkg::k_sub_imm || kind == cds_pkg::k_xor_imm)
         |-> st.pc == $past(st.pc, 7) + 16'h0002;
   endproperty
   a_imm_pc: assert property (p_imm_pc)
      else $error("immediate instruction not two bytes");

   property p_pair_sp;
      st.done && kind == cds_pkg::k_pair_sp
         |-> st.sp == hl && $past(st.cnt) == 5'h04;
   endproperty
   a_pair_sp: assert property (p_pair_sp)
      else $error("stack pointer load wrong");

   property p_swap_de;
      st.done && kind == cds_pkg::k_swap_de
         |-> hl == $past({st.regs[`CDS_IDX_D], st.regs[`CDS_IDX_E]});
   endproperty
   a_swap_de: assert property (p_swap_de)
      else $error("pair swap wrong");

   property p_swap_stk;
      st.done && kind == cds_pkg::k_swap_stk
         |-> $past(st.cnt) == 5'h11;
   endproperty
   a_swap_stk: assert property (p_swap_stk)
      else $error("stack swap not 18 cycles");

endmodule // cds_decode_core

// ---- core/cds_defs.svh ----
// Opcode, cycle-count and reset constants for the decode subset
`ifndef CDS_DEFS_SVH
`define CDS_DEFS_SVH

`define CDS_OP_RET_PEVEN  8'he8
`define CDS_OP_RET_PODD   8'he0
`define CDS_OP_RET_ZERO   8'hc8
`define CDS_OP_ROT_RIGHT  8'h0f
`define CDS_OP_SET_CARRY  8'h37
`define CDS_OP_SUBB_MEM   8'h9e
`define CDS_OP_SUBB_IMM   8'hde
`define CDS_OP_SUB_MEM    8'h96
`define CDS_OP_SUB_IMM    8'hd6
`define CDS_OP_XOR_MEM    8'hae
`define CDS_OP_XOR_IMM    8'hee
`define CDS_OP_PAIR_SP    8'hf9
`define CDS_OP_SWAP_DE    8'heb
`define CDS_OP_SWAP_STK   8'he3
`define CDS_GRP_SUBB_REG  5'h13
`define CDS_GRP_SUB_REG   5'h12
`define CDS_GRP_XOR_REG   5'h15
`define CDS_RST_TOP       2'h3
`define CDS_RST_LOW       3'h7

`define CDS_CYC_REG       5'h04
`define CDS_CYC_MEM       5'h07
`define CDS_CYC_RET_NO    5'h05
`define CDS_CYC_RET_YES   5'h0b
`define CDS_CYC_PAIR_SP   5'h05
`define CDS_CYC_SWAP_STK  5'h12
`define CDS_CYC_RESTART   5'h0b

`define CDS_F_CARRY       0
`define CDS_F_PARITY      2
`define CDS_F_HALF        4
`define CDS_F_ZERO        6
`define CDS_F_SIGN        7

`define CDS_IDX_D         3'h2
`define CDS_IDX_E         3'h3
`define CDS_IDX_H         3'h4
`define CDS_IDX_L         3'h5
`define CDS_IDX_A         3'h7

`define CDS_FLAGS_RST     8'h02
`define CDS_PC_RST        16'h0000
`define CDS_SP_RST        16'h0000

`endif

// ---- core/cds_pkg.sv ----
// Types shared by the decode subset core and its ALU
package cds_pkg;

   typedef enum logic [1:0] {
      st_fetch  = 2'h0,
      st_decode = 2'h1,
      st_exec   = 2'h3
   } cds_state_t;

   typedef enum logic [3:0] {
      k_none, k_ret_cond, k_rot, k_setc,
      k_sub_reg, k_sub_mem, k_sub_imm,
      k_xor_reg, k_xor_mem, k_xor_imm,
      k_pair_sp, k_swap_de, k_swap_stk, k_restart
   } cds_kind_t;

   typedef enum logic [1:0] {
      alu_sub, alu_xor, alu_rot, alu_setc
   } cds_alu_t;

   typedef struct packed {
      logic [15:0] addr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
   } cds_mem_req_t;

   typedef struct packed {
      cds_state_t      fsm;
      logic [4:0]      cnt;
      logic [7:0]      op;
      logic            take;
      logic [7:0][7:0] regs;
      logic [7:0]      flags;
      logic [15:0]     sp;
      logic [15:0]     pc;
      logic [7:0]      tmp;
      cds_mem_req_t    mem;
      logic            done;
   } cds_core_st_t;

endpackage

// ---- testbench/cds_decode_core_tb.sv ----
// Self-checking bench for the decode subset core
`timescale 1ns/1ps
module cds_decode_core_tb;
   logic                  clk_in = 1'b0;
   logic                  srst_in = 1'b1;
   logic [7:0]            mem_rdata;
   cds_pkg::cds_mem_req_t mem_req;
   logic                  done;
   logic [7:0]            acc;
   logic [7:0]            flags;
   logic [15:0]           pc;
   logic [15:0]           sp;
   int                    fails = 0;
   int                    n_compared = 0;
   int                    cyc = 0;
   logic [15:0]           n0;
   logic [15:0]           pc_q = 16'h0000;
   logic [15:0]           sp_q = 16'h0000;
   logic [7:0]            a_q = 8'h00;
   logic [7:0]            f_q = 8'h02;
   logic [7:0]            rv [0:7] = '{default: 8'h00};

   cds_decode_core u_dut (
      .clk_in       (clk_in),
      .srst_in      (srst_in),
      .mem_rdata_in (mem_rdata),
      .mem_req_out  (mem_req),
      .done_out     (done),
      .acc_out      (acc),
      .flags_out    (flags),
      .pc_out       (pc),
      .sp_out       (sp)
   );

   cds_prog_mem u_mem (
      .clk_in    (clk_in),
      .req_in    (mem_req),
      .rdata_out (mem_rdata)
   );

   initial
   begin
      forever #5 clk_in = ~clk_in;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Place one program byte at the expected fetch address
   task automatic put(input logic [7:0] b);
      u_mem.mem[pc_q] = b;
      pc_q++;
   endtask

   // Cycles from the previous retire to this one: clock count plus one
   task automatic step(output logic [15:0] n);
      n = 16'h0001;
      do
      begin
         @(posedge clk_in);
         #1;
         n++;
      end while (done !== 1'b1 && n < 16'd40);
      chk(pc, pc_q);
      chk(sp, sp_q);
   endtask

   // Operation kind from opcode: exclusive-OR, with borrow, plain
   function automatic int kd(input logic [7:0] op);
      return op[5] ? 2 : (op[3] ? 1 : 0);
   endfunction

   task automatic alu(input int k, input logic [7:0] b);
      logic       bin;
      logic [8:0] d;
      logic       ac;
      bin = (k == 1) ? f_q[0] : 1'b0;
      d = {1'b0, a_q} - {1'b0, b} - 9'(bin);
      ac = ({1'b0, a_q[3:0]} + {1'b0, ~b[3:0]} + 5'(!bin)) > 5'h0f;
      if (k == 2)
      begin
         d = {1'b0, a_q ^ b};
         ac = 1'b0;
      end
      a_q = d[7:0];
      f_q = {d[7], d[7:0] == 8'h00, 1'b0, ac, 1'b0, ~^d[7:0], 1'b1, d[8]};
   endtask

   task automatic ck_af();
      chk(acc, a_q);
      chk(flags, f_q);
   endtask

   task automatic t_restart();
      put(8'hff);
      pc_q = 16'h0038;
      sp_q = 16'hfffe;
      step(n0);
      chk(n0, 16'd12);
      chk(u_mem.mem[16'hffff], 16'h0000);
      chk(u_mem.mem[16'hfffe], 16'h0002);
      $display("test restart done");
   endtask

   task automatic t_exchange();
      u_mem.mem[16'hfffe] = 8'h34;
      u_mem.mem[16'hffff] = 8'h12;
      put(8'he3);
      step(n0);
      chk(n0, 16'd19);
      chk(u_mem.mem[16'hfffe], 16'h0000);
      chk(u_mem.mem[16'hffff], 16'h0000);
      put(8'hf9);
      sp_q = 16'h1234;
      step(n0);
      chk(n0, 16'd6);
      put(8'heb);
      step(n0);
      chk(n0, 16'd5);
      rv[2] = 8'h12;
      rv[3] = 8'h34;
      put(8'hf9);
      sp_q = 16'h0000;
      step(n0);
      chk(n0, 16'd6);
      $display("test exchange done");
   endtask

   task automatic t_imm();
      logic [7:0] ops [4] = '{8'hee, 8'hd6, 8'hde, 8'hee};
      logic [7:0] imm [4] = '{8'h5a, 8'h70, 8'h01, 8'hff};
      for (int i = 0; i < 4; i++)
      begin
         put(ops[i]);
         put(imm[i]);
         alu(kd(ops[i]), imm[i]);
         step(n0);
         chk(n0, 16'd8);
         ck_af();
      end
      $display("test immediate done");
   endtask

   task automatic t_reg();
      logic [7:0] base [3] = '{8'h90, 8'h98, 8'ha8};
      logic [7:0] op;
      for (int g = 0; g < 3; g++)
         for (int r = 0; r < 8; r++)
            if (r != 6)
            begin
               op = base[g] | 8'(r);
               put(op);
               alu(kd(op), (r == 7) ? a_q : rv[r]);
               step(n0);
               chk(n0, 16'd5);
               ck_af();
            end
      $display("test register done");
   endtask

   task automatic t_mem();
      logic [7:0] ops [3] = '{8'h96, 8'h9e, 8'hae};
      for (int i = 0; i < 3; i++)
      begin
         u_mem.mem[16'h0000] = 8'h5c + 8'(i * 37);
         put(ops[i]);
         alu(kd(ops[i]), u_mem.mem[16'h0000]);
         step(n0);
         chk(n0, 16'd8);
         ck_af();
      end
      $display("test memory operand done");
   endtask

   task automatic t_rot();
      put(8'h0f);
      f_q[0] = a_q[0];
      a_q = {a_q[0], a_q[7:1]};
      step(n0);
      chk(n0, 16'd5);
      chk(acc, a_q);
      chk(flags, f_q);
      put(8'h37);
      f_q[0] = 1'b1;
      step(n0);
      chk(n0, 16'd5);
      chk(flags, f_q);
      $display("test rotate and carry done");
   endtask

   task automatic t_ret();
      logic [7:0]  op;
      logic [15:0] tgt;
      logic        take;
      for (int i = 0; i < 4; i++)
      begin
         put(8'hee);
         put(a_q ^ (i[1] ? 8'h01 : 8'h03));
         alu(2, a_q ^ (i[1] ? 8'h01 : 8'h03));
         step(n0);
         ck_af();
         op = i[0] ? 8'he0 : 8'he8;
         take = i[0] ? !f_q[2] : f_q[2];
         put(op);
         if (take)
         begin
            tgt = 16'h0100 + 16'(i * 64);
            u_mem.mem[sp_q] = tgt[7:0];
            u_mem.mem[sp_q + 16'h0001] = tgt[15:8];
            sp_q = sp_q + 16'h0002;
            pc_q = tgt;
         end
         step(n0);
         chk(n0, take ? 16'd12 : 16'd6);
      end
      // Zero result, then return on zero taken
      put(8'hee);
      put(a_q);
      alu(2, a_q);
      step(n0);
      ck_af();
      put(8'hc8);
      u_mem.mem[sp_q] = 8'h00;
      u_mem.mem[sp_q + 16'h0001] = 8'h03;
      sp_q = sp_q + 16'h0002;
      pc_q = 16'h0300;
      step(n0);
      chk(n0, 16'd12);
      $display("test conditional return done");
   endtask

   // Hang guard
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         results();
      end
   end

   initial
   begin
      repeat (3) @(posedge clk_in);
      #1;
      chk(acc, 16'h0000);
      chk(flags, 16'h0002);
      chk(pc, 16'h0000);
      chk(sp, 16'h0000);
      srst_in = 1'b0;
      pc_q = 16'h0001;
      step(n0);
      t_restart();
      t_exchange();
      t_imm();
      t_reg();
      t_mem();
      t_rot();
      t_ret();
      results();
   end
endmodule // cds_decode_core_tb

// ---- testbench/cds_prog_mem.sv ----
// Zero-wait program and data memory partner for the decode core
`timescale 1ns/1ps
module cds_prog_mem (
   // Clock
   input  wire logic                  clk_in,
   // Request and answer
   input  wire cds_pkg::cds_mem_req_t req_in,
   output logic [7:0]                 rdata_out
);
   logic [7:0] mem [0:65535];
   logic [7:0] data_q = 8'h00;

   initial
   begin
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'h00;
   end

   // Answer while rd stands, else the inverse of the last byte read
   always @(posedge clk_in)
   begin
      if (req_in.rd)
         data_q <= mem[req_in.addr];
      if (req_in.wr)
         mem[req_in.addr] <= req_in.wdata;
   end

   assign rdata_out = req_in.rd ? mem[req_in.addr] : ~data_q;
endmodule // cds_prog_mem
